// ==== dv/dps_duty_sequencer_tb.sv ====
// Self-checking bench for the tick-stepped duty sequencer
`timescale 1ns/1ps
`default_nettype none
module dps_duty_sequencer_tb;
  import dps_pkg::*;
  localparam int MC = 100;
  localparam int TC = 1000;
  logic        clk, rst, avs_read, avs_write;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest, pwm_out_pin, status_toggle_out;
  logic        interval_tick_event, transfer_done_event;
  logic [15:0] high_cyc, period_cyc;
  int          num_errors, compares, cyc, done_cnt, nt, last_tick;
  dps_duty_sequencer #(.MASTER_CYC(MC), .TICK_CYC(TC)) DUT (
    .clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pwm_out_pin(pwm_out_pin), .status_toggle_out(status_toggle_out),
    .interval_tick_event(interval_tick_event),
    .transfer_done_event(transfer_done_event));
  dps_led_model led (.clk(clk), .rst(rst), .pwm_out_pin(pwm_out_pin),
    .high_cyc(high_cyc), .period_cyc(period_cyc));
  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Done pulses counted and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && transfer_done_event === 1'b1) done_cnt <= done_cnt + 1;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Avalon master: hold request until waitrequest sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Only the bench timeout bounds this wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  // Wait for a tick pulse, count it, check the status pin
  task automatic tick(output int n);
    do begin
      @(posedge clk);
    end while (interval_tick_event !== 1'b1);
    // Tick to tick spacing, independent of the time spent waiting
    n = cyc - last_tick;
    last_tick = cyc;
    nt++;
    chk(status_toggle_out, 32'(nt % 2));
    repeat (2) @(posedge clk);
  endtask
  task automatic t_reset();
    chk(pwm_out_pin, 0);
    chk(status_toggle_out, 0);
    for (int i = 0; i < TABLE_LEN; i++)
      rd(OFS_RAM + 8'(4 * i), 32'((10 + 20 * i) * 640));
    rd(OFS_CMP, 32'h0000_1900);
    rd(OFS_SRC, 32'h0000_0000);
    rd(OFS_CNT, 32'h0000_0005);
    bus(1'b1, 8'h40, 32'h0000_ffff);
    rd(8'h40, 32'h0000_0000);
    // Single byte lane write keeps the upper lane of entry 0
    avs_byteenable <= 4'h1;
    bus(1'b1, OFS_RAM, 32'h0000_00ff);
    avs_byteenable <= 4'hf;
    rd(OFS_RAM, 32'h0000_19ff);
    bus(1'b1, OFS_RAM, 32'h0000_1900);
    rd(OFS_RAM, 32'h0000_1900);
    $display("TB: test reset done");
  endtask
  task automatic t_start();
    bus(1'b1, OFS_CTRL, 32'h0000_000f);
    repeat (3 * MC) @(posedge clk);
    chk(period_cyc, MC);
    chk(high_cyc, 10);
    $display("TB: test start done");
  endtask
  task automatic t_seq();
    int n;
    for (int k = 1; k <= 5; k++) begin
      tick(n);
      if (k > 1) chk(n, TC);
      rd(OFS_CMP, 32'((10 + 20 * (k - 1)) * 640));
      if (k <= 2) chk(q, (k == 1) ? 32'h0000_1900 : 32'h0000_4b00);
      rd(OFS_SRC, 32'(2 * k));
      rd(OFS_CNT, 32'(5 - k));
      chk(done_cnt, 32'(k == 5));
      repeat (3 * MC) @(posedge clk);
      chk(high_cyc, 32'(10 + 20 * (k - 1)));
    end
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0001, 1);
    $display("TB: test sequence done");
  endtask
  task automatic t_reload();
    int n;
    tick(n);
    rd(OFS_CMP, 32'h0000_e100);
    bus(1'b1, OFS_STATUS, 32'h0000_0001);
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0001, 0);
    bus(1'b1, OFS_SRC, 32'h0000_0000);
    bus(1'b1, OFS_CNT, 32'h0000_0005);
    tick(n);
    rd(OFS_CMP, 32'h0000_1900);
    chk(done_cnt, 1);
    $display("TB: test reload done");
  endtask
  task automatic t_dma_off();
    int n;
    bus(1'b1, OFS_CTRL, 32'h0000_0007);
    tick(n);
    rd(OFS_SRC, 32'h0000_0002);
    rd(OFS_CNT, 32'h0000_0004);
    $display("TB: test dma off done");
  endtask
  task automatic report_and_stop();
    $display("TB: compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    done_cnt = 0;
    nt = 0;
    last_tick = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_start();
    t_seq();
    t_reload();
    t_dma_off();
    report_and_stop();
  end
endmodule // dps_duty_sequencer_tb
`default_nettype wire

// ==== dv/dps_led_model.sv ====
// LED load model measuring width and period of the pulse train
`timescale 1ns/1ps
`default_nettype none
module dps_led_model (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   pwm_out_pin,
  output logic [15:0] high_cyc,
  output logic [15:0] period_cyc
);
  logic [15:0] hcnt;
  logic [15:0] pcnt;
  logic        prev;
  // Latch counts at each rising edge of the pin, then restart them
  always_ff @(posedge clk) begin
    if (rst) begin
      hcnt <= 16'h0000;
      pcnt <= 16'h0000;
      prev <= 1'b0;
      high_cyc <= 16'h0000;
      period_cyc <= 16'h0000;
    end else begin
      prev <= pwm_out_pin;
      if (pwm_out_pin && !prev) begin
        high_cyc <= hcnt;
        period_cyc <= pcnt;
        hcnt <= 16'h0001;
        pcnt <= 16'h0001;
      end else begin
        hcnt <= hcnt + 16'(pwm_out_pin);
        pcnt <= pcnt + 16'h0001;
      end
    end
  end
endmodule // dps_led_model
`default_nettype wire

// ==== hdl/dps_duty_sequencer.sv ====
// Pulse-width generator with duty stepped by a tick-driven transfer
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - master channel and slave channel run together
// - slave waveform drives the pulse output pin
// - master period is 2 ms
// - slave one-count restarts each period, sets width
// - interval tick every 500 ms
// - each interval tick with DMA enabled and count left launches one transfer
// - transfer moves RAM data into registers
// - each transfer moves one 16-bit item
// - destination is the slave compare register
// - source starts at first table entry
// - transfer count loaded with five
// - duty starts at ten percent
// - duty steps 10,30,50,70,90 percent
// - done event after ninety; software reloads
// - status pin inverts on each duty update; the code inverts it on every interval tick, with or without a transfer
// - entry equals percent times 640 counts
// - first duty change one second after start
module dps_duty_sequencer #(
  parameter int MASTER_CYC = dps_pkg::MASTER_CYC,
  parameter int TICK_CYC   = dps_pkg::TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             pwm_out_pin,
  output logic             status_toggle_out,
  output logic             interval_tick_event,
  output logic             transfer_done_event
);
  import dps_pkg::*;

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic             run01;
    logic             run2;
    logic             dma_en;
    logic [15:0]      src;
    logic [15:0]      cnt;
    logic             done_flag;
    logic             done_pulse;
    logic             tick_pulse;
    logic [15:0]      cmp;
    logic [15:0]      eff;
    logic [15:0]      scnt;
    logic             pwm;
    logic             stat;
    dps_dma_st_t      st;
    logic [4:0][15:0] ram;
  } dps_state_t;

  dps_state_t s_reg;
  dps_state_t s_next;
  logic       master_tick;
  logic       ch2_tick;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  dps_interval_timer #(.PERIOD(MASTER_CYC)) u_master (
    .clk  (clk),
    .rst  (rst),
    .run  (s_reg.run01),
    .tick (master_tick)
  );

  dps_interval_timer #(.PERIOD(TICK_CYC)) u_interval (
    .clk  (clk),
    .rst  (rst),
    .run  (s_reg.run2),
    .tick (ch2_tick)
  );

  logic        req;
  logic        wr_go;
  logic        start01;
  logic [2:0]  ram_idx;
  logic [15:0] ram_word;
  logic [31:0] wmerged;
  logic [31:0] rd_mux;
  logic [47:0] lhs;
  logic [47:0] rhs;
  logic [2:0]  bus_idx;

  // Bus request decode and read mux
  always_comb begin
    req = avs_read | avs_write;
    wr_go = avs_write & s_reg.ack;
    bus_idx = 3'((avs_address - OFS_RAM) >> 2);
    ram_idx = s_reg.src[3:1];
    ram_word = (ram_idx < 3'(TABLE_LEN)) ? s_reg.ram[ram_idx] : 16'h0000;
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_CTRL: begin
        rd_mux[CTRL_CH0] = s_reg.run01;
        rd_mux[CTRL_CH1] = s_reg.run01;
        rd_mux[CTRL_CH2] = s_reg.run2;
        rd_mux[CTRL_DMA] = s_reg.dma_en;
      end
      OFS_SRC: rd_mux[15:0] = s_reg.src;
      OFS_CNT: rd_mux[15:0] = s_reg.cnt;
      OFS_STATUS: begin
        rd_mux[STAT_DONE] = s_reg.done_flag;
        rd_mux[STAT_PIN]  = s_reg.stat;
        rd_mux[STAT_BUSY] = s_reg.cnt != 16'h0000;
      end
      OFS_CMP: rd_mux[15:0] = s_reg.cmp;
      OFS_EFF: rd_mux[15:0] = s_reg.eff;
      default: begin
        if (avs_address >= OFS_RAM && avs_address < OFS_RAM_END
            && avs_address[1:0] == 2'b00) begin
          rd_mux[15:0] = s_reg.ram[bus_idx];
        end
      end
    endcase
    wmerged = merge(rd_mux, avs_writedata, avs_byteenable);
    // both start bits together start ch0 and ch1
    start01 = wr_go && avs_address == OFS_CTRL
              && wmerged[CTRL_CH0] && wmerged[CTRL_CH1] && !s_reg.run01;
    // Width in full-scale counts scaled onto the cycle period
    lhs = 48'(s_reg.scnt) * 48'(FULL_COUNTS);
    rhs = 48'(s_reg.eff) * 48'(MASTER_CYC);
  end

  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.done_pulse = 1'b0;
    s_next.tick_pulse = ch2_tick;
    // Answer one cycle after the request is seen
    s_next.ack = req & ~s_reg.ack;
    if (req && !s_reg.ack) begin
      s_next.rdata = avs_read ? rd_mux : 32'h0000_0000;
    end

    // slave one-count restarted by each master period
    // compare latched only at period start
    if (master_tick || start01) begin
      s_next.scnt = 16'h0000;
      s_next.eff = s_reg.cmp;
    end else if (s_reg.scnt != 16'hFFFF) begin
      s_next.scnt = s_reg.scnt + 16'h0001;
    end
    // slave width drives the output pin
    s_next.pwm = s_reg.run01 && !start01 && (lhs < rhs);

    // status pin inverts on each tick
    if (ch2_tick) begin
      s_next.stat = ~s_reg.stat;
    end

    // tick with count left launches a transfer
    case (s_reg.st)
      DPS_IDLE: begin
        if (ch2_tick && s_reg.dma_en && s_reg.cnt != 16'h0000) begin
          s_next.st = DPS_MOVE;
        end
      end
      DPS_MOVE: begin
        // one 16-bit RAM word into compare
        s_next.cmp = ram_word;
        s_next.src = s_reg.src + SRC_STEP;
        s_next.cnt = s_reg.cnt - 16'h0001;
        // done event when the last item moves
        if (s_reg.cnt == 16'h0001) begin
          s_next.done_pulse = 1'b1;
        end
        s_next.st = DPS_IDLE;
      end
      default: s_next.st = DPS_IDLE;
    endcase

    // Register writes; software reload of source and count
    if (wr_go) begin
      case (avs_address)
        OFS_CTRL: begin
          s_next.run01 = wmerged[CTRL_CH0] & wmerged[CTRL_CH1];
          s_next.run2 = wmerged[CTRL_CH2];
          s_next.dma_en = wmerged[CTRL_DMA];
        end
        OFS_SRC: s_next.src = wmerged[15:0];
        OFS_CNT: s_next.cnt = wmerged[15:0];
        OFS_STATUS: begin
          if (wmerged[STAT_DONE]) begin
            s_next.done_flag = 1'b0;
          end
        end
        OFS_CMP: s_next.cmp = wmerged[15:0];
        default: begin
          if (avs_address >= OFS_RAM && avs_address < OFS_RAM_END
              && avs_address[1:0] == 2'b00) begin
            s_next.ram[bus_idx] = wmerged[15:0];
          end
        end
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (s_next.done_pulse) begin
      s_next.done_flag = 1'b1;
    end
  end

  // State register with table and duty preset
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.cmp <= CMP_RST;
      s_reg.eff <= CMP_RST;
      // source at first entry, count five
      s_reg.src <= SRC_RST;
      s_reg.cnt <= CNT_RST;
      s_reg.st <= DPS_IDLE;
      for (int i = 0; i < TABLE_LEN; i++) begin
        s_reg.ram[i] <= 16'((DUTY_FIRST_PCT + DUTY_STEP_PCT * i)
                            * COUNTS_PER_PCT);
      end
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = ~s_reg.ack;
  assign pwm_out_pin = s_reg.pwm;
  assign status_toggle_out = s_reg.stat;
  assign interval_tick_event = s_reg.tick_pulse;
  assign transfer_done_event = s_reg.done_pulse;

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_duty_reset;
    disable iff (1'b0)
    rst |=> s_reg.cmp == CMP_RST && s_reg.cnt == CNT_RST;
  endproperty
  a_duty_reset: assert property (p_duty_reset)
    else $error("duty or count not preset after reset");

  property p_tick_move;
    (ch2_tick && s_reg.st == DPS_IDLE && s_reg.dma_en
     && s_reg.cnt != 16'h0000) |=> ##1 s_reg.cmp == $past(ram_word);
  endproperty
  a_tick_move: assert property (p_tick_move)
    else $error("tick did not load compare from table");

  property p_src_step;
    s_reg.st == DPS_MOVE && !wr_go |=>
      s_reg.src == $past(s_reg.src) + SRC_STEP
      && s_reg.cnt == $past(s_reg.cnt) - 16'h0001;
  endproperty
  a_src_step: assert property (p_src_step)
    else $error("source or count did not step");

  property p_done;
    transfer_done_event |-> s_reg.cnt == 16'h0000 || $past(wr_go);
  endproperty
  a_done: assert property (p_done)
    else $error("done event with count left");

  property p_toggle;
    ch2_tick |=> status_toggle_out != $past(status_toggle_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("status pin did not invert on tick");

  property p_eff_hold;
    !master_tick && !start01 |=> s_reg.eff == $past(s_reg.eff);
  endproperty
  a_eff_hold: assert property (p_eff_hold)
    else $error("width changed inside a period");

  property p_width;
    s_reg.run01 && !start01 && lhs >= rhs |=> !pwm_out_pin;
  endproperty
  a_width: assert property (p_width)
    else $error("output high beyond the width");

  property p_period;
    master_tick |=> !master_tick [*2];
  endproperty
  a_period: assert property (p_period)
    else $error("master ticks too close");

  property p_idle_low;
    !s_reg.run01 |=> !pwm_out_pin;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("output high while stopped");

  property p_width_high;
    s_reg.run01 && !start01 && lhs < rhs |=> pwm_out_pin;
  endproperty
  a_width_high: assert property (p_width_high)
    else $error("output low inside the width");

  property p_stat_hold;
    !ch2_tick |=> status_toggle_out == $past(status_toggle_out);
  endproperty
  a_stat_hold: assert property (p_stat_hold)
    else $error("status pin moved without a tick");

  property p_done_single;
    transfer_done_event |=> !transfer_done_event;
  endproperty
  a_done_single: assert property (p_done_single)
    else $error("done event longer than one cycle");

  property p_ram_hold;
    !wr_go |=> s_reg.ram == $past(s_reg.ram);
  endproperty
  a_ram_hold: assert property (p_ram_hold)
    else $error("duty table changed without a write");

  property p_tick_event;
    ch2_tick |=> interval_tick_event;
  endproperty
  a_tick_event: assert property (p_tick_event)
    else $error("interval tick event missing");
endmodule // dps_duty_sequencer
`default_nettype wire

// ==== hdl/dps_interval_timer.sv ====
// Free-running interval timer with one-cycle end-of-period tick
`timescale 1ns/1ps
`default_nettype none
module dps_interval_timer #(
  parameter int PERIOD = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } dps_tmr_t;

  dps_tmr_t s_reg;
  dps_tmr_t s_next;

  // Count while running, wrap at the period end
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = 32'h0000_0000;
    end else if (s_reg.cnt == 32'(PERIOD - 1)) begin
      s_next.cnt = 32'h0000_0000;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;
endmodule // dps_interval_timer
`default_nettype wire

// ==== hdl/dps_pkg.sv ====
// Constants and types shared by the duty sequencer and its testbench
package dps_pkg;
  // Clock and time figures
  localparam int CLK_PERIOD_NS    = 100;
  localparam int MASTER_PERIOD_NS = 2_000_000;
  localparam int TICK_PERIOD_MS   = 500;
  localparam int MASTER_CYC = MASTER_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CYC = TICK_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;

  // Duty table: counts per percent, first entry, step, entries
  localparam int COUNTS_PER_PCT = 640;
  localparam int FULL_COUNTS    = 100 * COUNTS_PER_PCT;
  localparam int DUTY_FIRST_PCT = 10;
  localparam int DUTY_STEP_PCT  = 20;
  localparam int TABLE_LEN      = 5;

  // Reset values
  localparam logic [15:0] CMP_RST = 16'(DUTY_FIRST_PCT * COUNTS_PER_PCT);
  localparam logic [15:0] SRC_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0005;
  localparam logic [15:0] SRC_STEP = 16'h0002;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SRC    = 8'h04;
  localparam logic [7:0] OFS_CNT    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CMP    = 8'h10;
  localparam logic [7:0] OFS_EFF    = 8'h14;
  localparam logic [7:0] OFS_RAM    = 8'h20;
  localparam logic [7:0] OFS_RAM_END = 8'h34;

  // Control bit positions
  localparam int CTRL_CH0 = 0;
  localparam int CTRL_CH1 = 1;
  localparam int CTRL_CH2 = 2;
  localparam int CTRL_DMA = 3;
  // Status bit positions
  localparam int STAT_DONE = 0;
  localparam int STAT_PIN  = 1;
  localparam int STAT_BUSY = 2;

  // Transfer engine states
  typedef enum logic {DPS_IDLE, DPS_MOVE} dps_dma_st_t;
endpackage
